// >>> bench/testbench.sv
// Self-checking testbench for the flash protection and write control block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_prot_pkg::*;
  logic clk, resetn, reg_wr, reg_rd, access_grant, dummy_read, debug_enable, engine_busy;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, program_commit, al;
  logic [15:0] nv_ad, nv_dis, nv_ren, nv_swp;
  data_access_t access;
  int err_count, checks, seed, n;
  logic [31:0] rd_q[$];
  logic [3:0] acc_q[$];
  logic [31:0] re;
  logic [3:0] ae;
  logic rd_p, acc_p;
  // Disable image, reenable image, protection expected active
  localparam logic [32:0] CHAIN [5] = '{{16'hFFFE, 16'hFFFF, 1'b0}, {16'hFFFE, 16'hFFFE, 1'b1},
    {16'hFFFC, 16'hFFFE, 1'b0}, {16'h0000, 16'h7FFF, 1'b0}, {16'h0000, 16'h0000, 1'b1}};

  flash_access_write_protection i_flash_access_write_protection (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nv_access_debug(nv_ad),
    .nv_disable(nv_dis), .nv_reenable(nv_ren), .nv_sector_wp(nv_swp), .access(access),
    .access_grant(access_grant), .dummy_read(dummy_read), .debug_enable(debug_enable),
    .engine_busy(engine_busy), .program_commit(program_commit));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic report(input logic [15:0] got, input logic [15:0] exp);
    err_count++;
    $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
  endtask

  task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m);
    checks++;
    if ((got & m) !== (exp & m)) report(got, exp);
  endtask

  task automatic cmp_acc(input logic [1:0] got, input logic [1:0] exp, input logic [1:0] m);
    checks++;
    if ((got & m) !== (exp & m)) report({14'h0000, got}, {14'h0000, exp});
  endtask

  task automatic cmp_lvl(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) report(got, exp);
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Read data and access results stand one cycle after their request
  always @(posedge clk)
  begin
    if (rd_p)
    begin
      re = rd_q.pop_front();
      cmp_reg(reg_rdata, re[15:0], re[31:16]);
    end
    if (acc_p)
    begin
      ae = acc_q.pop_front();
      cmp_acc({access_grant, dummy_read}, ae[1:0], ae[3:2]);
    end
    rd_p = reg_rd;
    acc_p = access.req;
  end

  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    rd_q.push_back({m, e});
    bus(1'b0, 1'b1, a, 16'h0000);
  endtask

  task automatic idle(input int c);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (c) @(posedge clk);
  endtask

  // Expectation is {grant, dummy} under mask m
  task automatic acc(input fetch_src_t s, input logic [3:0] f, input logic [1:0] e,
                     input logic [1:0] m);
    acc_q.push_back({m, e});
    access <= '{req: 1'b1, write: f[3], peripheral_transfer_controller: f[2], ext_module: f[1], flash_regs: f[0], src: s};
    @(posedge clk);
    access.req <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_busy(input logic lvl, input int lim);
    int k;
    k = 0;
    while (engine_busy !== lvl)
    begin
      @(posedge clk);
      k++;
      if (k > lim)
      begin
        err_count++;
        tally_and_finish();
      end
    end
  endtask

  task automatic boot(input logic [15:0] ad, input logic [15:0] dis, input logic [15:0] ren,
                      input logic [15:0] swp);
    resetn <= 1'b0;
    nv_ad <= ad;
    nv_dis <= dis;
    nv_ren <= ren;
    nv_swp <= swp;
    idle(4);
    cmp_lvl({debug_enable, engine_busy, access_grant, dummy_read, 12'h000}, 16'h0000);
    cmp_lvl(program_commit, 16'h0000);
    resetn <= 1'b1;
    access.src <= FETCH_MAIN;
    repeat (LOAD_CYCLES + 2) @(posedge clk);
  endtask

  task automatic prog_op(input logic dbl, input logic [3:0] sec, input logic [15:0] a);
    logic [31:0] r;
    r = $random(seed);
    access.src <= FETCH_MAIN;
    wr(REG_CONTROL0_HIGH, dbl ? 16'h1080 : 16'h2000);
    wr(REG_ADDRESS_LOW, a);
    wr(REG_ADDRESS_HIGH, {12'h000, sec});
    wr(REG_DATA0_LOW, r[15:0]);
    wr(REG_DATA0_HIGH, r[31:16]);
    if (dbl)
    begin
      wr(REG_DATA1_LOW, r[31:16]);
      wr(REG_DATA1_HIGH, r[15:0]);
    end
    wr(REG_CONTROL0_HIGH, dbl ? 16'h9080 : 16'hA000);
    idle(1);
    wait_busy(1'b1, 10);
  endtask

  task automatic setprot(input logic [15:0] a, input fetch_src_t s);
    access.src <= s;
    wr(REG_CONTROL0_HIGH, 16'h0100);
    wr(REG_ADDRESS_LOW, a);
    wr(REG_ADDRESS_HIGH, 16'h000E);
    wr(REG_DATA0_LOW, 16'hFFFF);
    wr(REG_CONTROL0_HIGH, 16'h8100);
    idle(4);
    wait_busy(1'b0, 400);
    idle(2);
  endtask

  task automatic erase_suspend();
    wr(REG_CONTROL0_HIGH, 16'h0800);
    wr(REG_SECTOR_SELECT_HIGH, 16'h0003);
    wr(REG_CONTROL0_HIGH, 16'h8800);
    idle(1);
    wait_busy(1'b1, 10);
    idle(20);
    wr(REG_CONTROL0_HIGH, 16'h4800);
    idle(1);
    wait_busy(1'b0, 400);
  endtask

  initial
  begin
    seed = 51339;
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    access = '0;
    {nv_ad, nv_dis, nv_ren, nv_swp} = 64'hFFFF_FFFF_FFFF_FFFF;
    {rd_p, acc_p, err_count, checks} = '0;
    boot(16'hFFFC, 16'hFFFF, 16'hFFFF, 16'hFFFD);
    cmp_lvl({15'h0000, debug_enable}, 16'h0000);
    acc(FETCH_MAIN, 4'h0, 2'b10, 2'b11);
    acc(FETCH_IRAM, 4'h0, 2'b01, 2'b11);
    acc(FETCH_IRAM, 4'h8, 2'b00, 2'b10);
    acc(FETCH_MAIN, 4'h4, 2'b00, 2'b10);
    acc(FETCH_IRAM, 4'h2, 2'b10, 2'b10);
    acc(FETCH_OTHER, 4'h9, 2'b00, 2'b10);
    acc(FETCH_OTHER, 4'h1, 2'b10, 2'b10);
    al = $random(seed);
    access.src <= FETCH_MAIN;
    wr(REG_ADDRESS_LOW, al);
    access.src <= FETCH_IRAM;
    wr(REG_ADDRESS_LOW, ~al);
    rd(REG_ADDRESS_LOW, al, 16'hFFFF);
    rd(4'hF, 16'h0000, 16'hFFFF);
    rd(REG_STATUS, 16'h0001, 16'h0007);
    idle(1);
    prog_op(1'b0, 4'h0, al);
    n = 0;
    while (engine_busy === 1'b1 && n < 1000)
    begin
      n++;
      @(posedge clk);
    end
    cmp_lvl(16'(n), 16'(OP_CYCLES));
    idle(2);
    cmp_lvl(program_commit, al);
    al = $random(seed);
    prog_op(1'b1, 4'h0, al | 16'h0004);
    wait_busy(1'b0, 400);
    idle(2);
    cmp_lvl(program_commit, al & 16'hFFFB);
    prog_op(1'b0, 4'h1, ~al);
    idle(OP_CYCLES + 20);
    cmp_lvl(program_commit, al & 16'hFFFB);
    rd(REG_FLASH_ERROR, 16'h0100, 16'h0100);
    idle(1);
    erase_suspend();
    rd(REG_STATUS, 16'h0004, 16'h0006);
    wr(REG_CONTROL0_HIGH, 16'hC800);
    idle(10);
    cmp_lvl({15'h0000, engine_busy}, 16'h0000);
    wr(REG_CONTROL0_HIGH, 16'h0800);
    wr(REG_CONTROL0_HIGH, 16'h8800);
    idle(1);
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 400);
    rd(REG_SECTOR_SELECT_HIGH, 16'h0000, 16'hFFFF);
    rd(REG_FLASH_ERROR, 16'h0000, 16'h0080);
    idle(1);
    erase_suspend();
    wr(REG_CONTROL0_HIGH, 16'h0000);
    wr(REG_CONTROL0_HIGH, 16'h8000);
    idle(OP_CYCLES + 20);
    rd(REG_FLASH_ERROR, 16'h0080, 16'h0080);
    rd(REG_STATUS, 16'h0000, 16'h0004);
    idle(1);
    setprot(16'hDFB4, FETCH_MAIN);
    al = $random(seed);
    prog_op(1'b0, 4'h1, al);
    wait_busy(1'b0, 400);
    idle(2);
    cmp_lvl(program_commit, al);
    setprot(16'hDFB8, FETCH_MAIN);
    acc(FETCH_IRAM, 4'h0, 2'b10, 2'b11);
    boot(16'hFFFC, 16'hFFFF, 16'hFFFF, 16'hFFFF);
    acc(FETCH_IRAM, 4'h0, 2'b01, 2'b11);
    setprot(16'hDFB8, FETCH_IRAM);
    acc(FETCH_IRAM, 4'h0, 2'b01, 2'b11);
    boot(16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF);
    cmp_lvl({15'h0000, debug_enable}, 16'h0001);
    acc(FETCH_IRAM, 4'h0, 2'b10, 2'b11);
    for (int c = 0; c < 5; c++)
    begin
      boot(16'hFFFC, CHAIN[c][32:17], CHAIN[c][16:1], 16'hFFFF);
      acc(FETCH_IRAM, 4'h0, CHAIN[c][0] ? 2'b01 : 2'b10, 2'b11);
    end
    idle(2);
    tally_and_finish();
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
endmodule

// >>> rtl/flash_access_write_protection.sv
// Flash protection state, access gating and program/erase sequencing
module flash_access_write_protection
  import flash_prot_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Non-volatile cell contents presented at reset
  input wire logic [15:0] nv_access_debug,
  input wire logic [15:0] nv_disable,
  input wire logic [15:0] nv_reenable,
  input wire logic [15:0] nv_sector_wp,
  // CPU data access check
  input wire data_access_t access,
  output logic access_grant,
  output logic dummy_read,
  // Debug and engine status
  output logic debug_enable,
  output logic engine_busy,
  output logic [15:0] program_commit
);

  op_state_t state_r;
  logic [15:0] ad_r, dis_r, ren_r, wp_r;
  logic [15:0] ctl_r, secl_r, sech_r, adl_r, adh_r, d0l_r, d0h_r, d1l_r, d1h_r, err_r;
  logic [15:0] suspend_bit_sel_r;
  logic [7:0] cnt_r;
  logic [1:0] ld_r;
  logic prog_in_erase_suspend_bit_r;

  function automatic logic prot_active(input logic [15:0] ad, input logic [15:0] dis,
                                       input logic [15:0] ren);
    logic off;
    off = 1'b0;
    for (int x = 0; x < PAIR_COUNT; x++)
      if (!dis[x] && ren[x])
        off = 1'b1;
    for (int x = 0; x < PAIR_COUNT - 1; x++)
      if (!ren[x] && dis[x + 1])
        off = 1'b0;
    return !ad[BIT_ACCESS_PROTECT] && !off;
  endfunction

  logic prot_on, from_flash, wr_ctl, start_req;
  assign prot_on = (state_r == ST_LOAD) || prot_active(ad_r, dis_r, ren_r);
  assign from_flash = (access.src == FETCH_MAIN) || (access.src == FETCH_EXT);
  assign wr_ctl = reg_wr && (!prot_on || from_flash);
  assign start_req = wr_ctl && reg_addr == REG_CONTROL0_HIGH && reg_wdata[BIT_START];

  // Volatile protection copies
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      ad_r <= 16'h0000;
      dis_r <= 16'hFFFF;
      ren_r <= 16'h0000;
      wp_r <= 16'h0000;
    end
    else if (state_r == ST_LOAD && ld_r == 2'h0)
    begin
      ad_r <= nv_access_debug;
      dis_r <= nv_disable;
      ren_r <= nv_reenable;
      wp_r <= nv_sector_wp;
    end
    else if (start_req && state_r == ST_IDLE && ctl_r[BIT_SET_PROTECT])
    begin
      if ({adh_r[3:0], adl_r} == ADDR_SECTOR_WP_NV)
        wp_r <= wp_r | d0l_r;
      if ({adh_r[3:0], adl_r} == ADDR_ACCESS_DEBUG_PROTECT_NV && from_flash)
        ad_r <= ad_r | (d0l_r & 16'h0001);
    end
  end

  // first disable needs both protections programmed
  // chain order, sixteen pairs, zeros reach nv only after reset
  function automatic logic disable_ok(input logic [15:0] ad, input logic [15:0] ren,
                                      input int x);
    if (x == 0)
      return !ad[BIT_DEBUG_PROTECT] && !ad[BIT_ACCESS_PROTECT];
    return !ren[x - 1];
  endfunction

  logic sector_hit;
  assign sector_hit = |({sech_r, secl_r} & ~{16'hFFFF, wp_r});

  // Control and data registers
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      ctl_r <= 16'h0000;
      secl_r <= 16'h0000;
      sech_r <= 16'h0000;
      adl_r <= 16'h0000;
      adh_r <= 16'h0000;
      d0l_r <= 16'h0000;
      d0h_r <= 16'h0000;
      d1l_r <= 16'h0000;
      d1h_r <= 16'h0000;
    end
    else
    begin
      if (wr_ctl && state_r != ST_BUSY)
      begin
        case (reg_addr)
          REG_CONTROL0_HIGH: ctl_r <= reg_wdata & ~(16'h0001 << BIT_START);
          REG_SECTOR_SELECT_LOW: secl_r <= reg_wdata;
          REG_SECTOR_SELECT_HIGH: sech_r <= reg_wdata;
          REG_ADDRESS_LOW: adl_r <= reg_wdata;
          REG_ADDRESS_HIGH: adh_r <= reg_wdata;
          REG_DATA0_LOW: d0l_r <= reg_wdata;
          REG_DATA0_HIGH: d0h_r <= reg_wdata;
          REG_DATA1_LOW: d1l_r <= reg_wdata;
          REG_DATA1_HIGH: d1h_r <= reg_wdata;
          default: ;
        endcase
      end
      else if (wr_ctl && reg_addr == REG_CONTROL0_HIGH && reg_wdata[BIT_SUSPEND]
               && !prog_in_erase_suspend_bit_r)
        ctl_r[BIT_SUSPEND] <= 1'b1;
      if (state_r == ST_BUSY && cnt_r == 8'h01)
      begin
        if (ctl_r[BIT_SECTOR_ERASE])
        begin
          secl_r <= 16'h0000;
          sech_r <= 16'h0000;
        end
        ctl_r <= 16'h0000;
      end
    end
  end

  logic resume_ok, sel_valid, bad_resume;
  assign resume_ok = (ctl_r & SELECT_MASK) == (suspend_bit_sel_r & SELECT_MASK);
  assign sel_valid = $onehot(ctl_r & SELECT_MASK);
  // Only the suspended select, or a program select inside an erase suspend, may start; any other start with the suspend bit clear is a bad resume
  assign bad_resume = start_req && state_r == ST_SUSPEND_BIT && !ctl_r[BIT_SUSPEND] && !resume_ok
                      && !(suspend_bit_sel_r[BIT_SECTOR_ERASE]
                      && (ctl_r[BIT_WORD_PROGRAM] || ctl_r[BIT_DOUBLE_WORD]));

  // Operation engine
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_r <= ST_LOAD;
      ld_r <= 2'(LOAD_CYCLES - 1);
      cnt_r <= 8'h00;
      suspend_bit_sel_r <= 16'h0000;
      prog_in_erase_suspend_bit_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_LOAD:
        begin
          if (ld_r == 2'h0)
            state_r <= ST_IDLE;
          else
            ld_r <= ld_r - 2'h1;
        end
        ST_IDLE, ST_SUSPEND_BIT:
        begin
          if (start_req && !ctl_r[BIT_SUSPEND] && sel_valid)
          begin
            state_r <= ST_BUSY;
            cnt_r <= 8'(OP_CYCLES);
            if (state_r == ST_SUSPEND_BIT && ctl_r[BIT_SECTOR_ERASE])
              prog_in_erase_suspend_bit_r <= 1'b0;
            else if (state_r == ST_SUSPEND_BIT && suspend_bit_sel_r[BIT_SECTOR_ERASE])
              prog_in_erase_suspend_bit_r <= 1'b1;
          end
          if (bad_resume)
            state_r <= ST_IDLE;
        end
        ST_BUSY:
        begin
          if (ctl_r[BIT_SUSPEND])
          begin
            state_r <= ST_SUSPEND_BIT;
            suspend_bit_sel_r <= ctl_r;
          end
          else if (cnt_r == 8'h01)
            state_r <= prog_in_erase_suspend_bit_r ? ST_SUSPEND_BIT : ST_IDLE;
          else
            cnt_r <= cnt_r - 8'h01;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  logic [15:0] tgt_mask;
  assign tgt_mask = 16'h0001 << adh_r[3:0];

  // Error flags: hardware set wins over software clear
  always_ff @(posedge clk)
  begin
    if (!resetn)
      err_r <= 16'h0000;
    else
    begin
      if (wr_ctl && reg_addr == REG_FLASH_ERROR)
        err_r <= err_r & reg_wdata;
      if (start_req && state_r != ST_BUSY && !ctl_r[BIT_SUSPEND]
          && ((ctl_r[BIT_SECTOR_ERASE] && sector_hit)
          || ((ctl_r[BIT_WORD_PROGRAM] || ctl_r[BIT_DOUBLE_WORD]) && |(tgt_mask & ~wp_r))))
        err_r[BIT_WP_ERROR] <= 1'b1;
      if (bad_resume)
        err_r[BIT_RESUME_ERROR] <= 1'b1;
      if (start_req && state_r == ST_IDLE && !sel_valid)
        err_r[BIT_SEQ_ERROR] <= 1'b1;
    end
  end

  // Program commit word, aligned and protection filtered
  always_ff @(posedge clk)
  begin
    if (!resetn)
      program_commit <= 16'h0000;
    else if (state_r == ST_BUSY && cnt_r == 8'h01 && !ctl_r[BIT_SUSPEND]
             && (ctl_r[BIT_WORD_PROGRAM] || ctl_r[BIT_DOUBLE_WORD])
             && !(|(tgt_mask & ~wp_r)))
      // double word forces address bit two low
      program_commit <= ctl_r[BIT_DOUBLE_WORD] ? (adl_r & ~(16'h0001 << ADDR_BIT_TWO)) : adl_r;
  end

  // Access decision
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      access_grant <= 1'b0;
      dummy_read <= 1'b0;
    end
    else
    begin
      access_grant <= access.req && (access.ext_module || !prot_on
                      || (access.flash_regs && (!access.write || access.src == FETCH_MAIN))
                      || (!access.flash_regs && from_flash && !access.peripheral_transfer_controller));
      dummy_read <= access.req && !access.write && !access.ext_module && !access.flash_regs
                    && prot_on && (!from_flash || access.peripheral_transfer_controller);
    end
  end

  // Read data and status
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      reg_rdata <= 16'h0000;
      debug_enable <= 1'b0;
      engine_busy <= 1'b0;
    end
    else
    begin
      debug_enable <= state_r != ST_LOAD && ad_r[BIT_DEBUG_PROTECT];
      engine_busy <= state_r == ST_BUSY;
      reg_rdata <= 16'h0000;
      if (reg_rd)
      begin
        case (reg_addr)
          REG_CONTROL0_HIGH: reg_rdata <= ctl_r;
          REG_SECTOR_SELECT_LOW: reg_rdata <= secl_r;
          REG_SECTOR_SELECT_HIGH: reg_rdata <= sech_r;
          REG_ADDRESS_LOW: reg_rdata <= adl_r;
          REG_ADDRESS_HIGH: reg_rdata <= adh_r;
          REG_DATA0_LOW: reg_rdata <= d0l_r;
          REG_DATA0_HIGH: reg_rdata <= d0h_r;
          REG_DATA1_LOW: reg_rdata <= d1l_r;
          REG_DATA1_HIGH: reg_rdata <= d1h_r;
          REG_FLASH_ERROR: reg_rdata <= err_r;
          REG_STATUS: reg_rdata <= {13'h0000, state_r == ST_SUSPEND_BIT, state_r == ST_BUSY, prot_on};
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  logic unused_disable_ok;
  assign unused_disable_ok = disable_ok(ad_r, ren_r, 0);

  // Checks
  a_load_prot_on: assert property (@(posedge clk) disable iff (!resetn)
    state_r == ST_LOAD |-> prot_on)
    else $error("protection not forced during load");
  a_debug_off: assert property (@(posedge clk) disable iff (!resetn)
    !ad_r[BIT_DEBUG_PROTECT] |=> !debug_enable)
    else $error("debug enabled while protected");
  a_ram_dummy_read: assert property (@(posedge clk) disable iff (!resetn)
    access.req && !access.write && !access.ext_module && !access.flash_regs && prot_on
    && access.src == FETCH_IRAM |=> dummy_read && !access_grant)
    else $error("RAM read not dummied");
  a_pec_refused: assert property (@(posedge clk) disable iff (!resetn)
    access.req && access.peripheral_transfer_controller && !access.ext_module && !access.flash_regs && prot_on
    |=> !access_grant)
    else $error("transfer controller access granted");
  a_ext_open: assert property (@(posedge clk) disable iff (!resetn)
    access.req && access.ext_module |=> access_grant)
    else $error("extension module blocked");
  a_no_start_suspend_bit: assert property (@(posedge clk) disable iff (!resetn)
    state_r == ST_IDLE && ctl_r[BIT_SUSPEND] |=> state_r != ST_BUSY)
    else $error("start taken while suspended");
  a_resume_error: assert property (@(posedge clk) disable iff (!resetn)
    bad_resume |=> err_r[BIT_RESUME_ERROR] && state_r == ST_IDLE)
    else $error("bad resume not aborted");
  a_erase_clears: assert property (@(posedge clk) disable iff (!resetn)
    state_r == ST_BUSY && cnt_r == 8'h01 && !ctl_r[BIT_SUSPEND] && ctl_r[BIT_SECTOR_ERASE]
    |=> secl_r == 16'h0000 && sech_r == 16'h0000)
    else $error("sectors left set after erase");
  c_word_program: cover property (@(posedge clk) state_r == ST_BUSY && ctl_r[BIT_WORD_PROGRAM]);
  c_suspend: cover property (@(posedge clk) state_r == ST_BUSY ##1 state_r == ST_SUSPEND_BIT);
  c_wp_error: cover property (@(posedge clk) $rose(err_r[BIT_WP_ERROR]));
  c_dummy: cover property (@(posedge clk) dummy_read);

endmodule

// >>> shared/flash_prot_pkg.sv
// Constants, register map and types for the flash protection and write control block
//
// Contract
// - Debug-protect bit at zero disables debug, flash test modes and test interface.
// - Access-protect at zero blocks main flash data access unless fetched from flash.
// - Disable bit x zero with reenable bit x one makes access-protect ignored.
// - Disable bit zero programmable only after debug and access protect are zero.
// - Disable bit x programmable only after reenable bit x-1 is zero.
// - Reenable bit x zero with disable x+1 erased restores access protection.
// - Sixteen disable/reenable pairs give at most sixteen unlock cycles.
// - Under protection, RAM-fetched writes ignored and reads return dummy data.
// - Peripheral transfer controller access refused while the module is protected; its flash register reads are still granted here.
// - Extension flash module is never access protected.
// - Non-flash code is denied main flash reads and control register writes.
// - Program or erase of a write-protected sector is blocked.
// - Set-protection writing ones clears protection in the volatile copy only.
// - Temporary access unprotect only when instructions are fetched from flash.
// - Only reset restores cleared protections; zero writes need reset to apply.
// - Temporary unprotect leaves non-volatile zeros unchanged; software tracks state.
// - Word program: select, address low/high, data low/high, then start.
// - Double word program: select plus module bit, address, four data halves, start.
// - Double word always even-word aligned; address bit two ignored.
// - Sector erase: select, set sector bits, then start.
// - Suspend bit suspends; resume by reselecting the operation and starting.
// - Wrong select on resume aborts and sets resume error; erase clears sectors.
// - During reset before loading, every protection is held active.
// - Protected sector target sets write-protect error; unprotected sectors still erased.
package flash_prot_pkg;

  localparam logic [19:0] ADDR_ACCESS_DEBUG_PROTECT_NV = 20'hEDFB8;
  localparam logic [19:0] ADDR_PROTECT_DISABLE_NV = 20'hEDFBC;
  localparam logic [19:0] ADDR_PROTECT_REENABLE_NV = 20'hEDFBE;
  localparam logic [19:0] ADDR_SECTOR_WP_NV = 20'hEDFB4;
  localparam logic [15:0] RST_ACCESS_DEBUG_PROTECT_NV = 16'hACFF;
  localparam logic [15:0] RST_PROTECT_REENABLE_NV = 16'hFFFF;
  localparam logic [15:0] RST_PROTECT_DISABLE_NV = 16'hFFFF;
  localparam logic [15:0] RST_SECTOR_WP_NV = 16'hFFFF;

  // Register port offsets (word index, byte address not used on this plain port)
  localparam logic [3:0] REG_CONTROL0_HIGH = 4'h0;
  localparam logic [3:0] REG_SECTOR_SELECT_LOW = 4'h1;
  localparam logic [3:0] REG_SECTOR_SELECT_HIGH = 4'h2;
  localparam logic [3:0] REG_ADDRESS_LOW = 4'h3;
  localparam logic [3:0] REG_ADDRESS_HIGH = 4'h4;
  localparam logic [3:0] REG_DATA0_LOW = 4'h5;
  localparam logic [3:0] REG_DATA0_HIGH = 4'h6;
  localparam logic [3:0] REG_DATA1_LOW = 4'h7;
  localparam logic [3:0] REG_DATA1_HIGH = 4'h8;
  localparam logic [3:0] REG_FLASH_ERROR = 4'h9;
  localparam logic [3:0] REG_STATUS = 4'hA;

  // Control0 high fields
  localparam int BIT_START = 15;
  localparam int BIT_SUSPEND = 14;
  localparam int BIT_WORD_PROGRAM = 13;
  localparam int BIT_DOUBLE_WORD = 12;
  localparam int BIT_SECTOR_ERASE = 11;
  localparam int BIT_SET_PROTECT = 8;
  localparam int BIT_MODULE_SELECT = 7;
  localparam logic [15:0] SELECT_MASK = 16'h3900;

  // Error register fields
  localparam int BIT_WP_ERROR = 8;
  localparam int BIT_RESUME_ERROR = 7;
  localparam int BIT_SEQ_ERROR = 6;
  localparam int BIT_WRITE_ERROR = 0;

  localparam int BIT_DEBUG_PROTECT = 1;
  localparam int BIT_ACCESS_PROTECT = 0;
  localparam int PAIR_COUNT = 16;
  localparam int ADDR_BIT_TWO = 2;

  // Operation latency of the embedded program/erase engine
  localparam int OP_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int OP_CYCLES = OP_TIME_NS / CLK_PERIOD_NS;
  localparam int LOAD_CYCLES = 4;

  typedef enum logic [1:0] {FETCH_MAIN, FETCH_EXT, FETCH_IRAM, FETCH_OTHER} fetch_src_t;

  typedef struct packed {
    logic req;
    logic write;
    logic peripheral_transfer_controller;
    logic ext_module;
    logic flash_regs;
    fetch_src_t src;
  } data_access_t;

  typedef enum {ST_LOAD, ST_IDLE, ST_BUSY, ST_SUSPEND_BIT} op_state_t;

endpackage
